// File: hw/exec_pkg.sv
package exec_pkg;
  // Instruction word layout (14-bit word)
  localparam int INSTR_W = 14;
  localparam int PC_W = 10;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 6;
  localparam int PAGE_W = 4;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;
  // Opcode patterns, compared under mask
  localparam logic [13:0] OPC_PAGE_WR = 14'h0020;
  localparam logic [13:0] MSK_PAGE_WR = 14'h3FF0;
  localparam logic [13:0] OPC_RETURN = 14'h0010;
  localparam logic [13:0] MSK_RETURN = 14'h3FFF;
  localparam logic [13:0] OPC_W2F = 14'h0040;
  localparam logic [13:0] MSK_W2F = 14'h3FC0;
  localparam logic [13:0] OPC_FREAD = 14'h0800;
  localparam logic [13:0] MSK_FREAD = 14'h3F80;
  localparam logic [13:0] OPC_IMM = 14'h1400;
  localparam logic [13:0] MSK_IMM = 14'h3F00;
  localparam logic [13:0] OPC_BRANCH = 14'h2000;
  localparam logic [13:0] MSK_BRANCH = 14'h3C00;
  localparam logic [13:0] OPC_CALL = 14'h3000;
  localparam logic [13:0] MSK_CALL = 14'h3C00;
  // Field positions
  localparam int DEST_BIT = 6;
  // Reset values
  localparam logic [9:0] PC_RST = 10'h000;
  localparam logic [7:0] WORK_RST = 8'h00;
  // Execution phases
  typedef enum logic [1:0] {
    PH_EXEC = 2'b01,
    PH_FLUSH = 2'b10
  } phase_t;
endpackage : exec_pkg

// File: hw/call_stack_if.sv
`timescale 1ns/1ps
// Push/pop link between the executer and its return-address stack
interface call_stack_if;
  logic push; // Push strobe
  logic pop; // Pop strobe
  logic [9:0] pushData; // Return address to store
  logic [9:0] topData; // Current top entry
  modport core (output push, output pop, output pushData, input topData);
  modport stack (input push, input pop, input pushData, output topData);
endinterface : call_stack_if

// File: hw/call_stack.sv
`timescale 1ns/1ps
module call_stack #(
  parameter int DEPTH = exec_pkg::STACK_DEPTH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Stack link
  call_stack_if.stack stk
);
  import exec_pkg::*;
  // All state in one struct
  typedef struct packed {
    logic [DEPTH-1:0][PC_W-1:0] mem;
    logic [SP_W-1:0] sp;
  } stk_state_t;
  stk_state_t s_q, s_d;

  // Top entry is the slot below the pointer; wraps when overused
  logic [SP_W-1:0] topIdx;
  assign topIdx = s_q.sp - 3'h1;
  assign stk.topData = s_q.mem[topIdx];

  // Next-state: push writes at pointer, pop drops pointer
  always_comb begin
    s_d = s_q;
    if (stk.push) begin
      s_d.mem[s_q.sp] = stk.pushData;
      s_d.sp = s_q.sp + 3'h1;
    end else if (stk.pop) begin
      s_d.sp = s_q.sp - 3'h1;
    end
  end

  // State register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : call_stack

// File: hw/mcu_move_branch_call_exec.sv
`timescale 1ns/1ps
module mcu_move_branch_call_exec (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Program memory
  output logic [exec_pkg::PC_W-1:0] pc,
  input wire logic [exec_pkg::INSTR_W-1:0] instr,
  // Data file
  output logic [exec_pkg::FADDR_W-1:0] fileAddr,
  input wire logic [exec_pkg::DATA_W-1:0] fileRdData,
  output logic [exec_pkg::DATA_W-1:0] fileWrData,
  output logic fileWe,
  // Secondary register page
  output logic [exec_pkg::PAGE_W-1:0] pageAddr,
  output logic [exec_pkg::DATA_W-1:0] pageWrData,
  output logic pageWe,
  // Core state
  output logic [exec_pkg::DATA_W-1:0] workReg,
  output logic zeroFlag,
  output logic carryFlag
);
  import exec_pkg::*;

  // Execution model
  // Each rising edge in the execute phase retires the word shown on instr.
  // Program memory answers in the same cycle, so no fetch stage is kept.
  // Jumps (branch, call, return) load the program counter at that edge.
  // The word that memory shows in the next cycle is the target word: the new PC
  // is already on the address, but that word is still thrown away.
  // That discarded cycle is the flush phase and gives jumps two cycles.
  // During flush the program counter holds, so the target word is fetched
  // and then executed at the following edge.
  // Writes to the data file and the register page leave as one-cycle
  // pulses from flops, one cycle after the instruction retires.
  // A read that follows a write to the same location therefore sees the
  // new value only if the file model writes at that pulse edge.
  // Carry is kept in state for the wider core but nothing here moves it.
  // Unknown words fall through every decode and act as a plain step.

  // Whole core state
  typedef struct packed {
    // Execute or flush
    phase_t ph;
    // Program counter and working register
    logic [PC_W-1:0] pc;
    logic [DATA_W-1:0] work;
    // Status bits
    logic z;
    logic c;
    // Pending data-file write
    logic [FADDR_W-1:0] fAddr;
    logic [DATA_W-1:0] fData;
    logic fWe;
    // Pending secondary-page write
    logic [PAGE_W-1:0] pAddr;
    logic [DATA_W-1:0] pData;
    logic pWe;
  } core_state_t;
  core_state_t s_q, s_d;

  call_stack_if stk ();

  // Return-address stack
  call_stack #(.DEPTH(STACK_DEPTH)) u_stack (
    .mclk(mclk),
    .arst_n(arst_n),
    .stk(stk)
  );

  // Fetched word decode
  // Each pattern is compared under its own mask, so operand bits are
  // ignored. The encodings do not overlap, which keeps the priority
  // chain below free of hidden ordering effects.
  // A decode that matches during flush is harmless: the next-state logic
  // and the stack strobes only act on it in the execute phase.
  logic isPage, isRet, isW2f, isFread, isImm, isBr, isCall;
  assign isPage = (instr & MSK_PAGE_WR) == OPC_PAGE_WR;
  assign isRet = (instr & MSK_RETURN) == OPC_RETURN;
  assign isW2f = (instr & MSK_W2F) == OPC_W2F;
  assign isFread = (instr & MSK_FREAD) == OPC_FREAD;
  assign isImm = (instr & MSK_IMM) == OPC_IMM;
  assign isBr = (instr & MSK_BRANCH) == OPC_BRANCH;
  assign isCall = (instr & MSK_CALL) == OPC_CALL;

  // Data file is read combinationally at the operand address
  assign fileAddr = instr[FADDR_W-1:0];

  // Stack strobes only fire in the execute phase
  // Gating by phase stops a stale call or return seen during flush from
  // pushing or popping a second time.
  always_comb begin
    stk.push = (s_q.ph == PH_EXEC) && isCall;
    stk.pop = (s_q.ph == PH_EXEC) && isRet;
    stk.pushData = s_q.pc + 10'h001;
  end

  // Next-state: one instruction per cycle, jumps add a flush cycle
  always_comb begin
    s_d = s_q;
    s_d.fWe = 1'b0;
    s_d.pWe = 1'b0;
    case (s_q.ph)
      PH_EXEC: begin
        s_d.pc = s_q.pc + 10'h001;
        if (isPage) begin
          // Page write; flags untouched
          s_d.pAddr = instr[PAGE_W-1:0];
          s_d.pData = s_q.work;
          s_d.pWe = 1'b1;
        end else if (isRet) begin
          // Top entry is read before the pop lands at this same edge
          s_d.pc = stk.topData;
          s_d.ph = PH_FLUSH;
        end else if (isW2f) begin
          // Accumulator stays; flags untouched
          s_d.fAddr = instr[FADDR_W-1:0];
          s_d.fData = s_q.work;
          s_d.fWe = 1'b1;
        end else if (isFread) begin
          // Destination bit picks file write-back or working register
          if (instr[DEST_BIT]) begin
            s_d.fAddr = instr[FADDR_W-1:0];
            s_d.fData = fileRdData;
            s_d.fWe = 1'b1;
          end else begin
            s_d.work = fileRdData;
          end
          // Zero tracks the moved value whichever way it goes
          s_d.z = (fileRdData == 8'h00);
        end else if (isImm) begin
          // Constant lands in the working register; status bits kept
          s_d.work = instr[DATA_W-1:0];
        end else if (isBr) begin
          // Stack untouched; full 10-bit target replaces the counter
          s_d.pc = instr[PC_W-1:0];
          s_d.ph = PH_FLUSH;
        end else if (isCall) begin
          // Return address was pushed by the strobe logic above
          s_d.pc = instr[PC_W-1:0];
          s_d.ph = PH_FLUSH;
        end else begin
          // Unknown word: plain step, nothing else moves
          s_d.ph = PH_EXEC;
        end
      end
      PH_FLUSH: begin
        // Discarded fetch: the word fetched at the new PC lands next
        s_d.ph = PH_EXEC;
      end
      default: begin
        s_d.ph = PH_EXEC;
      end
    endcase
  end

  // State register
  // Reset parks the core in execute at address zero, so the first word
  // retires at the first edge after release with no dummy cycle.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      s_q.ph <= PH_EXEC;
      s_q.pc <= PC_RST;
      s_q.work <= WORK_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  // Only the file address is combinational: it must reach the data file
  // in the same cycle as the word that names it, or reads would lag.
  assign pc = s_q.pc;
  assign fileWrData = s_q.fData;
  assign fileWe = s_q.fWe;
  assign pageAddr = s_q.pAddr;
  assign pageWrData = s_q.pData;
  assign pageWe = s_q.pWe;
  assign workReg = s_q.work;
  assign zeroFlag = s_q.z;
  assign carryFlag = s_q.c;
endmodule : mcu_move_branch_call_exec

// File: dv/mcu_exec_monitor.sv
`timescale 1ns/1ps
module mcu_exec_monitor (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Memories
  input wire logic [9:0] pc,
  input wire logic [13:0] instr,
  input wire logic [5:0] fileAddr,
  input wire logic [7:0] fileRdData,
  input wire logic [7:0] fileWrData,
  input wire logic fileWe,
  input wire logic [3:0] pageAddr,
  input wire logic [7:0] pageWrData,
  input wire logic pageWe,
  // Core state
  input wire logic [7:0] workReg,
  input wire logic zeroFlag,
  input wire logic carryFlag
);
  import exec_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Execute cycle flag; the cycle after a jump is a flush and decodes nothing
  logic exec_q;
  wire jmp = (instr & MSK_CALL) == OPC_CALL || (instr & MSK_BRANCH) == OPC_BRANCH
    || instr == OPC_RETURN;
  wire pw = exec_q && (instr & MSK_PAGE_WR) == OPC_PAGE_WR;
  wire cl = exec_q && (instr & MSK_CALL) == OPC_CALL;
  wire br = exec_q && (instr & MSK_BRANCH) == OPC_BRANCH;
  wire im = exec_q && (instr & MSK_IMM) == OPC_IMM;
  wire wf = exec_q && (instr & MSK_W2F) == OPC_W2F;
  wire rd = exec_q && (instr & MSK_FREAD) == OPC_FREAD;
  // Tracks phases so a flushed word never satisfies an antecedent
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) exec_q <= 1'b1;
    else exec_q <= !(exec_q && jmp);
  end
  // Two quiet cycles: the flush after the jump and the cycle that follows it
  sequence quietTwo;
    !fileWe && !pageWe ##1 !fileWe && !pageWe;
  endsequence
  AST_PAGE_WR: assert property (pw |=> pageWe && pageAddr == $past(instr[3:0])
    && pageWrData == $past(workReg)) else $error("page write wrong");
  AST_CALL: assert property (cl |=> pc == $past(instr[9:0]) ##0 quietTwo)
    else $error("call target wrong");
  AST_BRANCH: assert property (br |=> pc == $past(instr[9:0]) ##1 $stable(pc))
    else $error("branch wrong");
  AST_IMM: assert property (im |=> workReg == $past(instr[7:0]) && $stable(zeroFlag))
    else $error("immediate load wrong");
  AST_W2F: assert property (wf |=> fileWe && fileWrData == $past(workReg))
    else $error("file write wrong");
  AST_RD_ACC: assert property (rd && !instr[DEST_BIT] |=> workReg == $past(fileRdData))
    else $error("read to register wrong");
  AST_RD_FILE: assert property (rd && instr[DEST_BIT] |=> fileWe && $stable(workReg))
    else $error("read to file wrong");
  AST_RD_ZERO: assert property (rd |=> zeroFlag == ($past(fileRdData) == 8'h00))
    else $error("zero flag wrong");
  AST_KEEP: assert property (pw || wf || cl || br |=> $stable({zeroFlag, carryFlag}))
    else $error("flags moved");
endmodule : mcu_exec_monitor

// File: dv/mcu_move_branch_call_exec_bench.sv
`timescale 1ns/1ps
module mcu_move_branch_call_exec_bench;
  import exec_pkg::*;
  // Clock, reset, memories and counters
  logic mclk = 0;
  logic arst_n = 0;
  logic [9:0] pc;
  logic [13:0] instr;
  logic [5:0] fileAddr, lastAddr;
  logic [7:0] fileRdData, fileWrData, pageWrData, workReg;
  logic [3:0] pageAddr;
  logic fileWe, pageWe, zeroFlag, carryFlag;
  logic [13:0] rom [1024];
  logic [7:0] df [64];
  logic [7:0] pg [16];
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  // Memories answer combinationally, a little after the edge
  assign #1 instr = rom[pc];
  assign #1 fileRdData = df[fileAddr];
  mcu_move_branch_call_exec i_mcu_move_branch_call_exec (.mclk, .arst_n, .pc, .instr,
    .fileAddr, .fileRdData, .fileWrData, .fileWe, .pageAddr, .pageWrData, .pageWe,
    .workReg, .zeroFlag, .carryFlag);
  initial begin
    forever #2 mclk = ~mclk;
  end
  // File write lands a cycle late, at the operand of the word before
  always @(posedge mclk) begin
    lastAddr <= fileAddr;
    if (fileWe === 1'b1) df[lastAddr] <= fileWrData;
    if (pageWe === 1'b1) pg[pageAddr] <= pageWrData;
    cyc <= cyc + 1;
    if (cyc == 300) begin
      n_fail++;
      wrap_up();
    end
  end
  task check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  // Reset for ten cycles, then run the loaded program
  task boot(input int n);
    arst_n = 0;
    repeat (10) @(posedge mclk);
    #1 arst_n = 1;
    repeat (n) @(posedge mclk);
    #1;
  endtask : boot
  task test_moves();
    rom = '{default: '0};
    df = '{default: '0};
    rom[0] = 14'h14A5;
    rom[1] = 14'h0045;
    rom[2] = 14'h1400;
    rom[3] = 14'h0805;
    rom[4] = 14'h0847;
    rom[5] = 14'h0023;
    boot(10);
    check("file", df[5], 10'h0A5);
    check("work", workReg, 10'h0A5);
    check("zero", zeroFlag, 10'h001);
    check("page", pg[3], 10'h0A5);
    check("carry", carryFlag, 10'h000);
    $display("moves done");
  endtask : test_moves
  task test_call();
    rom = '{default: '0};
    rom[0] = 14'h33FF;
    rom[1] = 14'h143C;
    rom[2] = 14'h2002;
    rom[1023] = 14'h0010;
    boot(1);
    check("call", pc, 10'h3FF);
    repeat (4) @(posedge mclk);
    #1;
    check("ret", pc, 10'h002);
    repeat (7) @(posedge mclk);
    #1;
    check("branch", pc, 10'h002);
    check("work", workReg, 10'h03C);
    $display("call done");
  endtask : test_call
  task wrap_up();
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    test_moves();
    test_call();
    wrap_up();
  end
endmodule : mcu_move_branch_call_exec_bench
bind mcu_move_branch_call_exec mcu_exec_monitor i_mcu_exec_monitor (.mclk, .arst_n, .pc,
  .instr, .fileAddr, .fileRdData, .fileWrData, .fileWe, .pageAddr, .pageWrData, .pageWe,
  .workReg, .zeroFlag, .carryFlag);
